// [rtl/swf_defs.svh]
/*
  Constants for the selective-wake frame configuration bank: register
  offsets, field positions, reset values and filter timing counts.
  Assumes the includer uses them with the widths noted beside each.
*/
`ifndef SWF_DEFS_SVH
`define SWF_DEFS_SVH

// Register offsets on the 7-bit serial register port
`define SWF_ADDR_PAYLOAD_BYTE_ONE 7'h32
`define SWF_ADDR_PAYLOAD_BYTE_ZERO 7'h33
`define SWF_ADDR_FD_TOLERANCE_CONFIG 7'h34
`define SWF_ADDR_WAKE_OSC_FINE_TRIM 7'h38
`define SWF_ADDR_WAKE_OPTIONS_COARSE_TRIM 7'h39
`define SWF_ADDR_OSC_CALIBRATION_HIGH 7'h3a
`define SWF_ADDR_OSC_CALIBRATION_LOW 7'h3b

// Field positions in the FD tolerance configuration register
`define SWF_FD_ENABLE_BIT 0
`define SWF_DOMINANT_FILTER_TIME_LSB 1
`define SWF_DOMINANT_FILTER_TIME_MSB 3
`define SWF_FD_BYPASS_BIT 4
`define SWF_FD_SUSPEND_BIT 5

// Field positions in the options register
`define SWF_OPT_COARSE_LSB 0
`define SWF_OPT_COARSE_MSB 4
`define SWF_OPT_RX_SELECT_BIT 7

// Trim key value that unlocks the trim and receiver fields
`define SWF_TRIM_KEY_OPEN 2'h3

// Reset values
`define SWF_RESET_PAYLOAD 8'h00
`define SWF_RESET_FD_CONFIG 8'h00
// Per-field reset values of the FD configuration, options, trim and calibration registers
`define SWF_RESET_FD_ENABLE 1'b0
`define SWF_RESET_DOMINANT_FILTER_TIME 3'h0
`define SWF_RESET_FD_BYPASS 1'b0
`define SWF_RESET_FD_SUSPEND 1'b0
`define SWF_RESET_RX_SELECT 1'b0
`define SWF_RESET_FINE_TRIM 8'h00
`define SWF_RESET_COARSE_TRIM 5'h00
`define SWF_RESET_CALIBRATION 8'h00

// Clock rate and dominant filter times
`define SWF_CLK_MHZ 25
`define SWF_FILT_T0_NS 50
`define SWF_FILT_T1_NS 100
`define SWF_FILT_T2_NS 150
`define SWF_FILT_T3_NS 200
`define SWF_FILT_T4_NS 250
`define SWF_FILT_T5_NS 300
`define SWF_FILT_T6_NS 380
`define SWF_FILT_T7_NS 387
// Least time, rounded up to whole clock cycles
`define SWF_NS_TO_CYC(t) ((((t) * `SWF_CLK_MHZ) + 999) / 1000)

`endif

// [rtl/swf_pkg.sv]
/*
  Types shared by the selective-wake frame configuration bank.
  Assumes nothing of its surroundings.
*/
package swf_pkg;

  typedef enum logic [2:0] {
    SWF_FILT_RECESSIVE = 3'b001,
    SWF_FILT_COUNTING = 3'b010,
    SWF_FILT_DOMINANT = 3'b100
  } swf_filt_state_type;

  typedef logic [7:0] swf_byte_type;

endpackage

// [rtl/swf_cmp_if.sv]
/*
  Carries one reference byte and one received byte to a byte comparator
  and brings its verdict back. Assumes one instance per payload byte.
*/
`timescale 1ns/1ps
interface swf_cmp_if;
  swf_pkg::swf_byte_type ref_byte;
  swf_pkg::swf_byte_type rx_byte;
  logic [3:0] dlc;
  logic used;
  logic equal;

  modport bank (
    output ref_byte,
    output rx_byte,
    output dlc,
    input used,
    input equal
  );

  modport engine (
    input ref_byte,
    input rx_byte,
    input dlc,
    output used,
    output equal
  );
endinterface

// [rtl/swf_byte_match.sv]
/*
  Compares one received payload byte with its reference byte and tells
  whether the frame's length code makes that byte take part.
  Assumes the bank drives the interface from the same clock.
*/
`timescale 1ns/1ps
module swf_byte_match #(
  parameter int BYTE_INDEX = 0
) (
  swf_cmp_if.engine cmp
);

  // Codes 8 and above all mean eight bytes, so a plain compare suffices
  always_comb begin
    cmp.used = ({28'h000_0000, cmp.dlc} > BYTE_INDEX);
    cmp.equal = (cmp.ref_byte == cmp.rx_byte);
  end

endmodule

// [rtl/swf_config_bank.sv]
/*
  Selective-wake frame configuration bank: payload reference bytes, FD
  tolerant-mode controls with the digital dominant filter, key-guarded
  oscillator trim, wake receiver select and calibration read-back.
  Assumes a serial register engine on the same clock presents decoded
  accesses, the trim key comes from another register of the device, and
  the receive pin is asynchronous to clk.
*/
`timescale 1ns/1ps
`include "swf_defs.svh"

module swf_config_bank #(
  parameter logic [7:0] FINE_TRIM_RESET = `SWF_RESET_FINE_TRIM,
  parameter logic [4:0] COARSE_TRIM_RESET = `SWF_RESET_COARSE_TRIM
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] trim_key,
  input wire logic bus_silence_expired,
  input wire logic [7:0] calibration_result_high,
  input wire logic [7:0] calibration_result_low,
  input wire logic rx_frame_valid,
  input wire logic [3:0] rx_dlc,
  input wire logic [7:0] rx_payload_byte_zero,
  input wire logic [7:0] rx_payload_byte_one,
  output logic payload_match,
  output logic payload_match_valid,
  input wire logic rx_dominant_pin,
  output logic rx_dominant_filtered,
  output logic fd_tolerant_enable,
  output logic error_counter_hold,
  output logic analog_filter_bypass,
  output logic [7:0] oscillator_trim_fine,
  output logic [4:0] oscillator_trim_coarse,
  output logic wake_receiver_select
);

  swf_pkg::swf_byte_type payload_byte_one_r, payload_byte_one_nxt;
  swf_pkg::swf_byte_type payload_byte_zero_r, payload_byte_zero_nxt;
  logic fd_enable_r, fd_enable_nxt;
  logic [2:0] filter_code_r, filter_code_nxt;
  logic bypass_r, bypass_nxt;
  logic suspend_r, suspend_nxt;
  logic [7:0] fine_trim_r, fine_trim_nxt;
  logic [4:0] coarse_trim_r, coarse_trim_nxt;
  logic rx_select_r, rx_select_nxt;
  logic [7:0] cal_high_r, cal_low_r;
  logic [7:0] rdata_r, rdata_nxt;
  logic key_open;

  // Calibration results are sampled so the read path sees a settled word
  always_ff @(posedge clk) begin
    if (reset) begin
      cal_high_r <= `SWF_RESET_CALIBRATION;
      cal_low_r <= `SWF_RESET_CALIBRATION;
    end else begin
      cal_high_r <= calibration_result_high;
      cal_low_r <= calibration_result_low;
    end
  end

  assign key_open = (trim_key == `SWF_TRIM_KEY_OPEN);

  always_comb begin
    payload_byte_one_nxt = payload_byte_one_r;
    payload_byte_zero_nxt = payload_byte_zero_r;
    fd_enable_nxt = fd_enable_r;
    filter_code_nxt = filter_code_r;
    bypass_nxt = bypass_r;
    suspend_nxt = suspend_r;
    fine_trim_nxt = fine_trim_r;
    coarse_trim_nxt = coarse_trim_r;
    rx_select_nxt = rx_select_r;
    if (reg_write) begin
      case (reg_addr)
        `SWF_ADDR_PAYLOAD_BYTE_ONE: begin
          payload_byte_one_nxt = reg_wdata;
        end
        `SWF_ADDR_PAYLOAD_BYTE_ZERO: begin
          payload_byte_zero_nxt = reg_wdata;
        end
        `SWF_ADDR_FD_TOLERANCE_CONFIG: begin
          fd_enable_nxt = reg_wdata[`SWF_FD_ENABLE_BIT];
          filter_code_nxt = reg_wdata[`SWF_DOMINANT_FILTER_TIME_MSB:`SWF_DOMINANT_FILTER_TIME_LSB];
          bypass_nxt = reg_wdata[`SWF_FD_BYPASS_BIT];
          suspend_nxt = reg_wdata[`SWF_FD_SUSPEND_BIT];
        end
        `SWF_ADDR_WAKE_OSC_FINE_TRIM: begin
          if (key_open) begin
            fine_trim_nxt = reg_wdata;
          end
        end
        `SWF_ADDR_WAKE_OPTIONS_COARSE_TRIM: begin
          if (key_open) begin
            coarse_trim_nxt = reg_wdata[`SWF_OPT_COARSE_MSB:`SWF_OPT_COARSE_LSB];
            rx_select_nxt = reg_wdata[`SWF_OPT_RX_SELECT_BIT];
          end
        end
        // Calibration registers and unmapped offsets drop the write
        default: begin
          payload_byte_one_nxt = payload_byte_one_r;
        end
      endcase
    end
    // Timeout wins over a software write in the same cycle
    if (bus_silence_expired) begin
      suspend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      payload_byte_one_r <= `SWF_RESET_PAYLOAD;
      payload_byte_zero_r <= `SWF_RESET_PAYLOAD;
      fd_enable_r <= `SWF_RESET_FD_ENABLE;
      filter_code_r <= `SWF_RESET_DOMINANT_FILTER_TIME;
      bypass_r <= `SWF_RESET_FD_BYPASS;
      suspend_r <= `SWF_RESET_FD_SUSPEND;
      fine_trim_r <= FINE_TRIM_RESET;
      coarse_trim_r <= COARSE_TRIM_RESET;
      rx_select_r <= `SWF_RESET_RX_SELECT;
    end else begin
      payload_byte_one_r <= payload_byte_one_nxt;
      payload_byte_zero_r <= payload_byte_zero_nxt;
      fd_enable_r <= fd_enable_nxt;
      filter_code_r <= filter_code_nxt;
      bypass_r <= bypass_nxt;
      suspend_r <= suspend_nxt;
      fine_trim_r <= fine_trim_nxt;
      coarse_trim_r <= coarse_trim_nxt;
      rx_select_r <= rx_select_nxt;
    end
  end

  // Read data is registered: valid the cycle after the read strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_read) begin
      case (reg_addr)
        `SWF_ADDR_PAYLOAD_BYTE_ONE: rdata_nxt = payload_byte_one_r;
        `SWF_ADDR_PAYLOAD_BYTE_ZERO: rdata_nxt = payload_byte_zero_r;
        `SWF_ADDR_FD_TOLERANCE_CONFIG: begin
          rdata_nxt = {2'b00, suspend_r, bypass_r, filter_code_r, fd_enable_r};
        end
        `SWF_ADDR_WAKE_OSC_FINE_TRIM: rdata_nxt = fine_trim_r;
        `SWF_ADDR_WAKE_OPTIONS_COARSE_TRIM: begin
          rdata_nxt = {rx_select_r, 2'b00, coarse_trim_r};
        end
        `SWF_ADDR_OSC_CALIBRATION_HIGH: rdata_nxt = cal_high_r;
        `SWF_ADDR_OSC_CALIBRATION_LOW: rdata_nxt = cal_low_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Payload compare against the reference bytes
  swf_cmp_if cmp_zero ();
  swf_cmp_if cmp_one ();

  assign cmp_zero.ref_byte = payload_byte_zero_r;
  assign cmp_zero.rx_byte = rx_payload_byte_zero;
  assign cmp_zero.dlc = rx_dlc;
  assign cmp_one.ref_byte = payload_byte_one_r;
  assign cmp_one.rx_byte = rx_payload_byte_one;
  assign cmp_one.dlc = rx_dlc;

  swf_byte_match #(.BYTE_INDEX(0)) u_match_zero (.cmp(cmp_zero));
  swf_byte_match #(.BYTE_INDEX(1)) u_match_one (.cmp(cmp_one));

  logic match_r, match_nxt;
  logic match_valid_r, match_valid_nxt;

  always_comb begin
    match_nxt = match_r;
    match_valid_nxt = rx_frame_valid;
    if (rx_frame_valid) begin
      // A byte beyond the frame's length cannot spoil the match
      match_nxt = (!cmp_zero.used || cmp_zero.equal) && (!cmp_one.used || cmp_one.equal);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      match_r <= 1'b0;
      match_valid_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
      match_valid_r <= match_valid_nxt;
    end
  end

  assign payload_match = match_r;
  assign payload_match_valid = match_valid_r;

  // Digital dominant filter on the synchronised receive pin
  localparam logic [3:0] FILT_CYC0 = 4'(`SWF_NS_TO_CYC(`SWF_FILT_T0_NS));
  localparam logic [3:0] FILT_CYC1 = 4'(`SWF_NS_TO_CYC(`SWF_FILT_T1_NS));
  localparam logic [3:0] FILT_CYC2 = 4'(`SWF_NS_TO_CYC(`SWF_FILT_T2_NS));
  localparam logic [3:0] FILT_CYC3 = 4'(`SWF_NS_TO_CYC(`SWF_FILT_T3_NS));
  localparam logic [3:0] FILT_CYC4 = 4'(`SWF_NS_TO_CYC(`SWF_FILT_T4_NS));
  localparam logic [3:0] FILT_CYC5 = 4'(`SWF_NS_TO_CYC(`SWF_FILT_T5_NS));
  localparam logic [3:0] FILT_CYC6 = 4'(`SWF_NS_TO_CYC(`SWF_FILT_T6_NS));
  localparam logic [3:0] FILT_CYC7 = 4'(`SWF_NS_TO_CYC(`SWF_FILT_T7_NS));

  logic dom_meta_r, dom_sync_r;
  logic [3:0] need_cyc;
  logic [3:0] filt_cnt_r, filt_cnt_nxt;
  logic filt_out_r, filt_out_nxt;
  swf_pkg::swf_filt_state_type filt_state_r, filt_state_nxt;

  always_ff @(posedge clk) begin
    if (reset) begin
      dom_meta_r <= 1'b0;
      dom_sync_r <= 1'b0;
    end else begin
      dom_meta_r <= rx_dominant_pin;
      dom_sync_r <= dom_meta_r;
    end
  end

  always_comb begin
    case (filter_code_r)
      3'h0: need_cyc = FILT_CYC0;
      3'h1: need_cyc = FILT_CYC1;
      3'h2: need_cyc = FILT_CYC2;
      3'h3: need_cyc = FILT_CYC3;
      3'h4: need_cyc = FILT_CYC4;
      3'h5: need_cyc = FILT_CYC5;
      3'h6: need_cyc = FILT_CYC6;
      default: need_cyc = FILT_CYC7;
    endcase
  end

  // Independent of the analog bypass bit, which only steers the front end
  always_comb begin
    filt_state_nxt = filt_state_r;
    filt_cnt_nxt = filt_cnt_r;
    case (filt_state_r)
      swf_pkg::SWF_FILT_RECESSIVE: begin
        filt_cnt_nxt = 4'h1;
        if (dom_sync_r) begin
          filt_state_nxt = (need_cyc <= 4'h1) ? swf_pkg::SWF_FILT_DOMINANT
                                              : swf_pkg::SWF_FILT_COUNTING;
        end
      end
      swf_pkg::SWF_FILT_COUNTING: begin
        if (!dom_sync_r) begin
          filt_state_nxt = swf_pkg::SWF_FILT_RECESSIVE;
        end else if (filt_cnt_r + 4'h1 >= need_cyc) begin
          filt_state_nxt = swf_pkg::SWF_FILT_DOMINANT;
        end else begin
          filt_cnt_nxt = filt_cnt_r + 4'h1;
        end
      end
      swf_pkg::SWF_FILT_DOMINANT: begin
        if (!dom_sync_r) begin
          filt_state_nxt = swf_pkg::SWF_FILT_RECESSIVE;
        end
      end
      default: begin
        filt_state_nxt = swf_pkg::SWF_FILT_RECESSIVE;
      end
    endcase
    // Outside FD tolerant mode the pin passes straight through
    if (fd_enable_r) begin
      filt_out_nxt = (filt_state_nxt == swf_pkg::SWF_FILT_DOMINANT);
    end else begin
      filt_out_nxt = dom_sync_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      filt_state_r <= swf_pkg::SWF_FILT_RECESSIVE;
      filt_cnt_r <= 4'h1;
      filt_out_r <= 1'b0;
    end else begin
      filt_state_r <= filt_state_nxt;
      filt_cnt_r <= filt_cnt_nxt;
      filt_out_r <= filt_out_nxt;
    end
  end

  assign rx_dominant_filtered = filt_out_r;

  // Control outputs
  assign fd_tolerant_enable = fd_enable_r;
  assign error_counter_hold = suspend_r & fd_enable_r;
  assign analog_filter_bypass = bypass_r;
  assign oscillator_trim_fine = fine_trim_r;
  assign oscillator_trim_coarse = coarse_trim_r;
  assign wake_receiver_select = rx_select_r;

endmodule

// [verif/swf_config_bank_properties.sv]
/*
  Concurrent checks on the selective-wake configuration bank ports.
  Assumes binding to swf_config_bank with one clock and sync reset.
*/
`timescale 1ns/1ps
module swf_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] trim_key,
  input wire logic bus_silence_expired,
  input wire logic rx_frame_valid,
  input wire logic payload_match_valid,
  input wire logic rx_dominant_pin,
  input wire logic rx_dominant_filtered,
  input wire logic fd_tolerant_enable,
  input wire logic error_counter_hold,
  input wire logic analog_filter_bypass,
  input wire logic [7:0] oscillator_trim_fine,
  input wire logic [4:0] oscillator_trim_coarse,
  input wire logic wake_receiver_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic wr38, wr39;
  assign wr38 = reg_write && reg_addr == 7'h38;
  assign wr39 = reg_write && reg_addr == 7'h39;
  sequence s_fd_off_run;
    !fd_tolerant_enable [*4];
  endsequence
  // Filter can only open after the pin stayed dominant through the sync stages
  sequence s_fd_rise;
    fd_tolerant_enable && $past(fd_tolerant_enable) && $rose(rx_dominant_filtered);
  endsequence
  a_fd_write_fields: assert property (reg_write && reg_addr == 7'h34 && !bus_silence_expired |=>
    fd_tolerant_enable == $past(reg_wdata[0]) && analog_filter_bypass == $past(reg_wdata[4]) &&
    error_counter_hold == ($past(reg_wdata[5]) && $past(reg_wdata[0])))
    else $error("fd config write not reflected");
  a_hold_needs_fd: assert property (error_counter_hold |-> fd_tolerant_enable)
    else $error("counter held without fd mode");
  a_silence_clears: assert property (bus_silence_expired |=> !error_counter_hold)
    else $error("silence timeout did not clear suspend");
  a_fine_locked: assert property (wr38 && trim_key != 2'h3 |=> $stable(oscillator_trim_fine))
    else $error("fine trim changed while locked");
  a_fine_open: assert property (wr38 && trim_key == 2'h3 |=>
    oscillator_trim_fine == $past(reg_wdata)) else $error("fine trim write lost");
  a_opt_locked: assert property (wr39 && trim_key != 2'h3 |=>
    $stable(oscillator_trim_coarse) && $stable(wake_receiver_select))
    else $error("options changed while locked");
  a_opt_open: assert property (wr39 && trim_key == 2'h3 |=>
    oscillator_trim_coarse == $past(reg_wdata[4:0]) && wake_receiver_select == $past(reg_wdata[7]))
    else $error("options write lost");
  a_fd_rsvd_zero: assert property (reg_read && reg_addr == 7'h34 |=> reg_rdata[7:6] == 2'b00)
    else $error("fd reserved bits not zero");
  a_opt_rsvd_zero: assert property (reg_read && reg_addr == 7'h39 |=> reg_rdata[6:5] == 2'b00)
    else $error("options reserved bits not zero");
  a_unmapped_zero: assert property (reg_read &&
    reg_addr inside {[7'h00:7'h31], [7'h35:7'h37], [7'h3c:7'h7f]} |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_match_pulse: assert property (payload_match_valid == $past(rx_frame_valid))
    else $error("match valid not one cycle after frame");
  a_filter_plain: assert property (s_fd_off_run |->
    rx_dominant_filtered == $past(rx_dominant_pin, 3)) else $error("plain path delay wrong");
  a_filter_min: assert property (s_fd_rise |->
    $past(rx_dominant_pin, 3) && $past(rx_dominant_pin, 4)) else $error("short dominant passed");
endmodule
bind swf_config_bank swf_checker i_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .trim_key(trim_key), .bus_silence_expired(bus_silence_expired),
  .rx_frame_valid(rx_frame_valid), .payload_match_valid(payload_match_valid),
  .rx_dominant_pin(rx_dominant_pin), .rx_dominant_filtered(rx_dominant_filtered),
  .fd_tolerant_enable(fd_tolerant_enable), .error_counter_hold(error_counter_hold),
  .analog_filter_bypass(analog_filter_bypass), .oscillator_trim_fine(oscillator_trim_fine),
  .oscillator_trim_coarse(oscillator_trim_coarse), .wake_receiver_select(wake_receiver_select));

// [verif/swf_can_bus_model.sv]
/*
  Far side of the wake receiver: dominant pulses and decoded frames.
  Assumes callers enter its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module swf_can_bus_model (
  input wire logic clk,
  output logic rx_dominant_pin,
  output logic rx_frame_valid,
  output logic [3:0] rx_dlc,
  output logic [7:0] rx_payload_byte_zero,
  output logic [7:0] rx_payload_byte_one
);
  initial begin
    rx_dominant_pin = 1'b0;
    rx_frame_valid = 1'b0;
    rx_dlc = 4'h0;
    rx_payload_byte_zero = 8'h00;
    rx_payload_byte_one = 8'h00;
  end
  // Bus recessive between pulses; dominant held n sampled cycles
  task automatic pulse(input int n);
    @(posedge clk);
    #1 rx_dominant_pin = 1'b1;
    repeat (n) @(posedge clk);
    #1 rx_dominant_pin = 1'b0;
  endtask
  // Fields are inverted once the frame strobe drops, so stale bytes and length differ from the sent ones
  task automatic frame(input logic [3:0] dlc, input logic [7:0] b0, input logic [7:0] b1);
    @(posedge clk);
    #1 rx_frame_valid = 1'b1;
    rx_dlc = dlc;
    rx_payload_byte_zero = b0;
    rx_payload_byte_one = b1;
    @(posedge clk);
    #1 rx_frame_valid = 1'b0;
    rx_dlc = ~dlc;
    rx_payload_byte_zero = ~b0;
    rx_payload_byte_one = ~b1;
  endtask
endmodule

// [verif/swf_config_bank_test.sv]
/*
  Self-checking bench for the selective-wake configuration bank.
  Assumes the bus model and checker files are compiled beforehand.
*/
`timescale 1ns/1ps
module swf_config_bank_test;
  logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, silence = 1'b0, seen;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, cal_h = 8'h00, cal_l = 8'h00, r, d, ef, eo, p0, p1;
  logic [1:0] trim_key = 2'h0;
  logic [31:0] seed = 32'h1005_ebbd;
  logic [6:0] fc;
  logic v, pin, fv, m, mv, fd, hold, byp, sel;
  logic [3:0] dlc;
  logic [7:0] b0, b1, fine;
  logic [4:0] coarse;
  int errors = 0, num_checks = 0, n;
  logic [6:0] addrs [9] = '{7'h32, 7'h33, 7'h34, 7'h38, 7'h39, 7'h3a, 7'h3b, 7'h35, 7'h40};
  logic [1:0] keys [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
  logic [6:0] frames [7] = '{7'h07, 7'h0d, 7'h12, 7'h24, 7'h27, 7'h4f, 7'h7a};
  always #20 clk = ~clk;
  swf_can_bus_model i_bus (.clk(clk), .rx_dominant_pin(pin), .rx_frame_valid(fv),
    .rx_dlc(dlc), .rx_payload_byte_zero(b0), .rx_payload_byte_one(b1));
  swf_config_bank i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(r), .trim_key(trim_key),
    .bus_silence_expired(silence), .calibration_result_high(cal_h),
    .calibration_result_low(cal_l), .rx_frame_valid(fv), .rx_dlc(dlc),
    .rx_payload_byte_zero(b0), .rx_payload_byte_one(b1), .payload_match(m),
    .payload_match_valid(mv), .rx_dominant_pin(pin), .rx_dominant_filtered(v),
    .fd_tolerant_enable(fd), .error_counter_hold(hold), .analog_filter_bypass(byp),
    .oscillator_trim_fine(fine), .oscillator_trim_coarse(coarse), .wake_receiver_select(sel));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int filt_cyc(input int code);
    int t;
    t = code < 6 ? 50 * (code + 1) : (code == 6 ? 380 : 387);
    return (t * 25 + 999) / 1000;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] wd);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = wd;
    reg_write = 1'b1;
    @(posedge clk);
    #1 reg_write = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk);
    #1 reg_read = 1'b0;
    chk(r, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      p1 = seed[7:0];
      p0 = seed[15:8];
      cal_h = seed[23:16];
      cal_l = seed[31:24];
      wr(7'h32, p1);
      wr(7'h33, p0);
      wr(7'h3a, ~cal_h);
      wr(7'h3b, ~cal_l);
      rd(7'h32, p1);
      rd(7'h33, p0);
      rd(7'h3a, cal_h);
      rd(7'h3b, cal_l);
    end
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      d = (i < 2) ? (8'he0 | 8'(i)) : (seed[7:0] | 8'hc0);
      wr(7'h34, d);
      rd(7'h34, d & 8'h3f);
      chk(fd, d[0]);
      chk(byp, d[4]);
      chk(hold, d[5] & d[0]);
    end
    wr(7'h34, 8'h21);
    @(posedge clk);
    #1 silence = 1'b1;
    @(posedge clk);
    #1 silence = 1'b0;
    chk(hold, 8'h00);
    rd(7'h34, 8'h01);
    ef = 8'h00;
    eo = 8'h00;
    foreach (keys[i]) begin
      trim_key = keys[i];
      seed = lfsr(seed);
      d = seed[7:0] | 8'h81;
      wr(7'h38, {3'b000, d[4:0]});
      wr(7'h39, d);
      if (keys[i] == 2'h3) begin
        ef = {3'b000, d[4:0]};
        eo = d & 8'h9f;
      end
      rd(7'h38, ef);
      rd(7'h39, eo);
      chk(fine, ef);
      chk({3'b000, coarse}, {3'b000, eo[4:0]});
      chk(sel, eo[7]);
    end
    trim_key = 2'h3;
    wr(7'h39, 8'h80);
    chk(sel, 8'h01);
    chk({3'b000, coarse}, 8'h00);
    foreach (frames[i]) begin
      fc = frames[i];
      i_bus.frame(fc[6:3], fc[2] ? p0 : ~p0, fc[1] ? p1 : ~p1);
      chk(mv, 8'h01);
      chk(m, fc[0]);
    end
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      wr(7'h34, {3'b000, seed[0], 3'(c), 1'b1});
      n = filt_cyc(c);
      // Boundary pair: one cycle short must be stopped, exact length must pass
      for (int k = 0; k < 2; k++) begin
        seen = 1'b0;
        i_bus.pulse(n - 1 + k);
        repeat (6) begin
          @(posedge clk);
          #1 seen = seen | (v === 1'b1);
        end
        chk(seen, 8'(k));
      end
    end
    wr(7'h34, 8'h00);
    seen = 1'b0;
    i_bus.pulse(1);
    repeat (6) begin
      @(posedge clk);
      #1 seen = seen | (v === 1'b1);
    end
    chk(seen, 8'h01);
    wrap_up();
  end
endmodule
